// *** design/qu_regs.svh ***
// Purpose: Register indexes, field positions and reset values of the quad serial pin block
// Assumes: Eight registers per channel, picked by the low three address lines
// Notes:   Definitions only
`ifndef QU_REGS_SVH
`define QU_REGS_SVH

// Register index inside one channel
`define QU_IDX_MCTL        3'h4
`define QU_IDX_LSR         3'h5
`define QU_IDX_MSTAT       3'h6

// Field positions
`define QU_MCTL_DTR_BIT    3'h0
`define QU_LSR_RX_WAIT_BIT 5'h00
`define QU_LSR_TX_ROOM_BIT 5'h05
`define QU_MSTAT_CTS_BIT   5'h04
`define QU_MSTAT_DSR_BIT   5'h05
`define QU_MSTAT_CAR_BIT   5'h07

// Reset values
`define QU_MCTL_RST        8'h00
`define QU_MEM_RST        8'h00

`endif

// *** design/qu_pkg.sv ***
// Purpose: Types of the quad serial pin block
// Assumes: Four channels, eight-bit host data
// Notes:   Constants live in qu_regs.svh
`default_nettype none

package qu_pkg;

  typedef enum logic [1:0] {QU_IDLE, QU_RD_WAIT, QU_RD_DRIVE} qu_bus_st_t;

  typedef struct packed {
    logic [1:0]       rst_sy;
    logic [2:0]       rw_sy;
    logic [2:0]       rd_sy;
    logic [2:0]       wr_sy;
    logic [3:0]       car_s1;
    logic [3:0]       car_s2;
    logic [3:0]       cts_s1;
    logic [3:0]       cts_s2;
    logic [3:0]       dsr_s1;
    logic [3:0]       dsr_s2;
    logic [3:0][7:0]  mctl;
    qu_bus_st_t       bus_st;
    logic [1:0]       rd_ch;
    logic [2:0]       rd_idx;
    logic [7:0]       dout;
    logic             oe;
    logic             rx_agg_n;
    logic             tx_agg_n;
    logic [3:0]       tx_en;
    logic [3:0]       rx_en;
    logic [3:0]       dtr_n;
    logic             osc;
    logic             tick;
  } qu_state_t;

  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [7:0]       rdata;
  } qu_mem_t;

endpackage

`default_nettype wire

// *** design/qu_regmem.sv ***
// Purpose: Byte store for the plain registers of all four channels
// Assumes: One write and one read port, read data one cycle after the request
// Notes:   Address is channel in the upper two bits, register index below
`default_nettype none
`include "qu_regs.svh"

module qu_regmem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  // Read port
  input  wire logic        rd_en,
  input  wire logic [4:0]  rd_addr,
  output logic      [7:0]  rd_data
);

  qu_pkg::qu_mem_t st_ff;
  qu_pkg::qu_mem_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr_en)
    begin
      nxt_st.mem[wr_addr] = wr_data;
    end
    if (rd_en)
    begin
      nxt_st.rdata = st_ff.mem[rd_addr];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '{mem: {32{`QU_MEM_RST}}, rdata: `QU_MEM_RST};
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rdata;

endmodule

`default_nettype wire

// *** design/qu_pins.sv ***
// Purpose: Host strobes, reset pin, aggregate ready pins and modem pins of a quad serial block
// Assumes: All pins synchronous to clk; FIFOs and shifters report readiness per channel
// Notes:   Data bus is split into in, out and output enable
// Operation
// - First mode: high reset clears control registers, outputs
// - Reset holds transmit and receive disabled
// - Second mode: reset pin is active low
// - Second mode uses one combined read/write strobe
// - Strobe falling edge writes selected register
// - Second mode: strobe rising edge drives selected register out; first mode: rd_n falling edge
// - One receive-ready output ORs all channels
// - Receive-ready low while any character waits
// - Receive-ready high when no characters remain
// - Per-channel receive status readable in registers
// - Transmit-ready low while any transmit slot free
// - Transmit-ready high only when all full
// - Crystal or external clock sets data rates
// - Per-channel active-low carrier-detect input
// - Active-low clear-to-send shown in status bit four
// - Per-channel active-low data-set-ready input
// - Ready signals never gate transmit or receive
// - Control bit zero set drives terminal-ready low
// - Control bit zero clear drives terminal-ready high
// - First mode: own chip select per channel
// - Second mode: address lines three, four pick channel
`default_nettype none
`include "qu_regs.svh"

module qu_pins (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Host bus
  input  wire logic        mode_16,
  input  wire logic        reset_pin,
  input  wire logic [3:0]  chip_sel_n,
  input  wire logic [4:0]  register_and_channel_address,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        rw_n,
  // Channel readiness from the FIFOs
  input  wire logic [3:0]  rx_char_avail,
  input  wire logic [3:0]  tx_room_avail,
  output logic             aggregate_receive_ready_n,
  output logic             aggregate_transmit_ready_n,
  // Reference clock
  input  wire logic        clock_or_crystal_in,
  output logic             oscillator_out,
  output logic             baud_ref_tick,
  // Modem pins
  input  wire logic [3:0]  carrier_detect_n,
  input  wire logic [3:0]  clear_to_send_n,
  input  wire logic [3:0]  data_set_ready_n,
  output logic      [3:0]  data_terminal_ready_n,
  // Channel enables
  output logic      [3:0]  tx_enable,
  output logic      [3:0]  rx_enable
);

  localparam qu_pkg::qu_state_t ST_RST = '{
    rw_sy:   3'h7,
    rd_sy:   3'h7,
    wr_sy:   3'h7,
    car_s1:   4'hF,
    car_s2:   4'hF,
    cts_s1:   4'hF,
    cts_s2:   4'hF,
    dsr_s1:   4'hF,
    dsr_s2:   4'hF,
    mctl:     {4{`QU_MCTL_RST}},
    bus_st:   qu_pkg::QU_IDLE,
    rx_agg_n: 1'b1,
    tx_agg_n: 1'b1,
    dtr_n:   4'hF,
    default: '0
  };

  qu_pkg::qu_state_t st_ff;
  qu_pkg::qu_state_t nxt_st;

  logic             rst_act;
  logic             sel_any;
  logic [1:0]       sel_ch;
  logic [2:0]       reg_idx;
  logic             rd_evt;
  logic             wr_evt;
  logic             drive_end;
  logic             mem_wr;
  logic             mem_rd;
  logic [7:0]       mem_rdata;
  logic [3:0][7:0]  mstat_w;
  logic [3:0][7:0]  lsr_w;

  // Reset pin polarity follows the interface mode
  assign rst_act = mode_16 ? st_ff.rst_sy[1] : !st_ff.rst_sy[1];

  assign reg_idx = register_and_channel_address[2:0];

  // Channel decode
  always_comb
  begin
    sel_any = 1'b0;
    sel_ch  = 2'h0;
    if (mode_16)
    begin
      sel_any = (chip_sel_n != 4'hF);
      if (!chip_sel_n[0])
      begin
        sel_ch = 2'h0;
      end
      else if (!chip_sel_n[1])
      begin
        sel_ch = 2'h1;
      end
      else if (!chip_sel_n[2])
      begin
        sel_ch = 2'h2;
      end
      else
      begin
        sel_ch = 2'h3;
      end
    end
    else
    begin
      sel_any = !chip_sel_n[0];
      sel_ch  = register_and_channel_address[4:3];
    end
  end

  // Strobe edges taken from the second synchroniser stage onward
  always_comb
  begin
    rd_evt    = 1'b0;
    wr_evt    = 1'b0;
    drive_end = !sel_any;
    if (mode_16)
    begin
      wr_evt    = st_ff.wr_sy[2] && !st_ff.wr_sy[1];
      rd_evt    = st_ff.rd_sy[2] && !st_ff.rd_sy[1];
      drive_end = drive_end || st_ff.rd_sy[1];
    end
    else
    begin
      wr_evt    = st_ff.rw_sy[2] && !st_ff.rw_sy[1];
      rd_evt    = !st_ff.rw_sy[2] && st_ff.rw_sy[1];
      drive_end = drive_end || wr_evt;
    end
    rd_evt = rd_evt && sel_any && !rst_act;
    wr_evt = wr_evt && sel_any && !rst_act;
  end

  // Writes to the read-only status indexes are dropped
  assign mem_wr = ce && wr_evt && (reg_idx != `QU_IDX_MCTL)
                  && (reg_idx != `QU_IDX_LSR) && (reg_idx != `QU_IDX_MSTAT);
  assign mem_rd = ce && rd_evt;

  // Per-channel status words
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      assign mstat_w[g] = ({7'h00, !st_ff.cts_s2[g]} << `QU_MSTAT_CTS_BIT)
                        | ({7'h00, !st_ff.dsr_s2[g]} << `QU_MSTAT_DSR_BIT)
                        | ({7'h00, !st_ff.car_s2[g]} << `QU_MSTAT_CAR_BIT);
      assign lsr_w[g] = ({7'h00, rx_char_avail[g]} << `QU_LSR_RX_WAIT_BIT)
                      | ({7'h00, tx_room_avail[g]} << `QU_LSR_TX_ROOM_BIT);
    end
  endgenerate

  always_comb
  begin
    nxt_st = st_ff;

    // Synchronisers
    nxt_st.rst_sy = {st_ff.rst_sy[0], reset_pin};
    nxt_st.rw_sy  = {st_ff.rw_sy[1:0], rw_n};
    nxt_st.rd_sy  = {st_ff.rd_sy[1:0], rd_n};
    nxt_st.wr_sy  = {st_ff.wr_sy[1:0], wr_n};
    nxt_st.car_s1 = carrier_detect_n;
    nxt_st.car_s2 = st_ff.car_s1;
    nxt_st.cts_s1 = clear_to_send_n;
    nxt_st.cts_s2 = st_ff.cts_s1;
    nxt_st.dsr_s1 = data_set_ready_n;
    nxt_st.dsr_s2 = st_ff.dsr_s1;

    // Buffered reference clock and its rising-edge tick
    nxt_st.osc  = clock_or_crystal_in;
    nxt_st.tick = clock_or_crystal_in && !st_ff.osc;

    // Aggregate ready pins
    nxt_st.rx_agg_n = !(|rx_char_avail);
    nxt_st.tx_agg_n = !(|tx_room_avail);

    // Control register writes
    if (wr_evt && (reg_idx == `QU_IDX_MCTL))
    begin
      nxt_st.mctl[sel_ch] = host_data_in;
    end

    // Read sequencing
    case (st_ff.bus_st)
      qu_pkg::QU_IDLE:
      begin
        if (rd_evt)
        begin
          nxt_st.rd_ch  = sel_ch;
          nxt_st.rd_idx = reg_idx;
          nxt_st.bus_st = qu_pkg::QU_RD_WAIT;
        end
      end
      qu_pkg::QU_RD_WAIT:
      begin
        case (st_ff.rd_idx)
          `QU_IDX_MCTL:  nxt_st.dout = st_ff.mctl[st_ff.rd_ch];
          `QU_IDX_LSR:   nxt_st.dout = lsr_w[st_ff.rd_ch];
          `QU_IDX_MSTAT: nxt_st.dout = mstat_w[st_ff.rd_ch];
          default:     nxt_st.dout = mem_rdata;
        endcase
        nxt_st.oe     = 1'b1;
        nxt_st.bus_st = qu_pkg::QU_RD_DRIVE;
      end
      qu_pkg::QU_RD_DRIVE:
      begin
        if (drive_end)
        begin
          nxt_st.oe     = 1'b0;
          nxt_st.bus_st = qu_pkg::QU_IDLE;
        end
      end
      default:
      begin
        nxt_st.oe     = 1'b0;
        nxt_st.bus_st = qu_pkg::QU_IDLE;
      end
    endcase

    // Terminal ready mirrors control bit zero, inverted
    for (int c = 0; c < 4; c++)
    begin
      nxt_st.dtr_n[c] = !nxt_st.mctl[c][`QU_MCTL_DTR_BIT];
    end

    // Enables depend on reset alone, never on modem lines
    nxt_st.tx_en = 4'hF;
    nxt_st.rx_en = 4'hF;

    if (rst_act)
    begin
      nxt_st.mctl     = {4{`QU_MCTL_RST}};
      nxt_st.dtr_n    = 4'hF;
      nxt_st.bus_st   = qu_pkg::QU_IDLE;
      nxt_st.oe       = 1'b0;
      nxt_st.dout     = 8'h00;
      nxt_st.rx_agg_n = 1'b1;
      nxt_st.tx_agg_n = 1'b1;
      nxt_st.tx_en   = 4'h0;
      nxt_st.rx_en   = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= ST_RST;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  qu_regmem u_regmem (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .wr_en   (mem_wr),
    .wr_addr ({sel_ch, reg_idx}),
    .wr_data (host_data_in),
    .rd_en   (mem_rd),
    .rd_addr ({sel_ch, reg_idx}),
    .rd_data (mem_rdata)
  );

  assign host_data_out              = st_ff.dout;
  assign host_data_oe               = st_ff.oe;
  assign aggregate_receive_ready_n  = st_ff.rx_agg_n;
  assign aggregate_transmit_ready_n = st_ff.tx_agg_n;
  assign oscillator_out             = st_ff.osc;
  assign baud_ref_tick              = st_ff.tick;
  assign data_terminal_ready_n      = st_ff.dtr_n;
  assign tx_enable                  = st_ff.tx_en;
  assign rx_enable                  = st_ff.rx_en;

  // Checks
  rst_outputs_a: assert property (@(posedge clk) disable iff (!nrst)
    rst_act && ce |=> tx_enable == 4'h0 && rx_enable == 4'h0
                      && data_terminal_ready_n == 4'hF && !host_data_oe)
    else $error("reset did not clear outputs");

  rst_low_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    (!mode_16 && !reset_pin && ce) [*4] |=> tx_enable == 4'h0)
    else $error("low reset pin ignored in second mode");

  read_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    rd_evt && ce ##1 ce && !rst_act |-> ##1 host_data_oe)
    else $error("read did not drive data bus");

  dtr_write_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_evt && ce && reg_idx == `QU_IDX_MCTL
    |=> data_terminal_ready_n[$past(sel_ch)] == !$past(host_data_in[0]))
    else $error("terminal ready does not follow control bit");

  rx_agg_low_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && !rst_act && rx_char_avail != 4'h0 |=> !aggregate_receive_ready_n)
    else $error("receive ready not low with data waiting");

  rx_agg_high_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && rx_char_avail == 4'h0 |=> aggregate_receive_ready_n)
    else $error("receive ready low with no data");

  tx_agg_level_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && !rst_act |=> aggregate_transmit_ready_n == ($past(tx_room_avail) == 4'h0))
    else $error("transmit ready wrong");

  cts_status_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(ce) && $past(ce, 2) |-> mstat_w[0][4] == !$past(clear_to_send_n[0], 2))
    else $error("clear to send status wrong");

  enable_free_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && !rst_act |=> tx_enable == 4'hF && rx_enable == 4'hF)
    else $error("enables gated outside reset");

  read_68_c: cover property (@(posedge clk) disable iff (!nrst)
    !mode_16 && rd_evt ##2 host_data_oe);
  write_16_c: cover property (@(posedge clk) disable iff (!nrst)
    mode_16 && wr_evt && reg_idx == `QU_IDX_MCTL);
  reset_pin_c: cover property (@(posedge clk) disable iff (!nrst)
    rst_act ##1 !rst_act);

endmodule

`default_nettype wire

// *** verification/qu_far_model.sv ***
// Purpose: Stand-in for the modems and the channel FIFOs on the far side
// Assumes: Bench changes the commands on the falling clock edge
// Notes:   Commands are asserted high, modem pins come out active low
`default_nettype none

module qu_far_model (
  // Commands, 1 = asserted
  input  wire logic [3:0] rx_set,
  input  wire logic [3:0] tx_set,
  input  wire logic [3:0] car_set,
  input  wire logic [3:0] cts_set,
  input  wire logic [3:0] dsr_set,
  // Pins toward the block
  output logic      [3:0] rx_char_avail,
  output logic      [3:0] tx_room_avail,
  output logic      [3:0] carrier_detect_n,
  output logic      [3:0] clear_to_send_n,
  output logic      [3:0] data_set_ready_n
);
  assign rx_char_avail    = rx_set;
  assign tx_room_avail    = tx_set;
  assign carrier_detect_n = ~car_set;
  assign clear_to_send_n  = ~cts_set;
  assign data_set_ready_n = ~dsr_set;
endmodule

`default_nettype wire

// *** verification/quad_uart_host_and_modem_pins_test.sv ***
// Purpose: Self-checking bench for the quad serial pin block
// Assumes: Inputs change on the falling edge, strobes spaced well apart
// Notes:   Modem and FIFO side comes from qu_far_model
`default_nettype none

module quad_uart_host_and_modem_pins_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, nrst, ce, mode_16, reset_pin, rd_n, wr_n, rw_n, xin;
  logic [3:0] chip_sel_n, rx_av, tx_av, car_n, cts_n, dsr_n, dtr_n, tx_en, rx_en;
  logic [3:0] rx_s, tx_s, car_s, cts_s, dsr_s;
  logic [4:0] addr;
  logic [7:0] din, dout, q;
  logic       oe, e, rxr_n, txr_n, osc, tick;
  int         n_errors = 0;
  int         total_checks = 0;
  int         ticks = 0;

  qu_far_model u_far (.rx_set(rx_s), .tx_set(tx_s), .car_set(car_s), .cts_set(cts_s),
    .dsr_set(dsr_s), .rx_char_avail(rx_av), .tx_room_avail(tx_av),
    .carrier_detect_n(car_n), .clear_to_send_n(cts_n), .data_set_ready_n(dsr_n));

  qu_pins u_dut (.clk(clk), .nrst(nrst), .ce(ce), .mode_16(mode_16), .reset_pin(reset_pin),
    .chip_sel_n(chip_sel_n), .register_and_channel_address(addr), .host_data_in(din),
    .host_data_out(dout), .host_data_oe(oe), .rd_n(rd_n), .wr_n(wr_n), .rw_n(rw_n),
    .rx_char_avail(rx_av), .tx_room_avail(tx_av), .aggregate_receive_ready_n(rxr_n),
    .aggregate_transmit_ready_n(txr_n), .clock_or_crystal_in(xin), .oscillator_out(osc),
    .baud_ref_tick(tick), .carrier_detect_n(car_n), .clear_to_send_n(cts_n),
    .data_set_ready_n(dsr_n), .data_terminal_ready_n(dtr_n), .tx_enable(tx_en),
    .rx_enable(rx_en));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (tick === 1'b1) ticks++;

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // One host access; the opposite edge of rw_n is made first with no chip selected
  task automatic bus(input logic [3:0] cs, input logic [4:0] a, input logic [7:0] d,
                     input logic rd);
    chip_sel_n = 4'hF;
    rw_n = ~rd;
    step(4);
    chip_sel_n = cs;
    addr = a;
    din = d;
    if (mode_16 && rd)
      rd_n = 1'b0;
    else if (mode_16)
      wr_n = 1'b0;
    else
      rw_n = rd;
    step(8);
    q = dout;
    e = oe;
    chip_sel_n = 4'hF;
    rd_n = 1'b1;
    wr_n = 1'b1;
    step(4);
  endtask

  task automatic t_reset;
    chk(8'(oe), 8'h00, "oe in reset");
    chk(8'({rxr_n, txr_n}), 8'h03, "ready pins");
    chk(8'(dtr_n), 8'h0F, "dtr in reset");
    chk(8'({tx_en, rx_en}), 8'h00, "enables");
    nrst = 1'b1;
    step(5);
    chk(8'({tx_en, rx_en}), 8'hFF, "run");
    reset_pin = 1'b1;
    step(5);
    chk(8'({tx_en, rx_en, txr_n}), 8'h01, "pin reset mode 1");
    reset_pin = 1'b0;
    step(5);
    $display("test reset done");
  endtask

  task automatic t_mode0;
    mode_16 = 1'b0;
    reset_pin = 1'b1;
    step(5);
    chk(8'(tx_en), 8'h0F, "high pin runs in mode 0");
    reset_pin = 1'b0;
    step(5);
    chk(8'({tx_en, rx_en}), 8'h00, "low pin resets");
    reset_pin = 1'b1;
    step(5);
    for (int c = 0; c < 4; c++) bus(4'hE, {2'(c), 3'h1}, 8'hA0 + 8'(c), 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      bus(4'hE, {2'(c), 3'h1}, 8'h00, 1'b1);
      chk(q, 8'hA0 + 8'(c), "mode 0 read back");
      chk(8'(e), 8'h01, "mode 0 drives bus");
    end
    bus(4'hE, {2'h3, 3'h4}, 8'h01, 1'b0);
    chk(8'(dtr_n), 8'h07, "dtr ch3 low");
    bus(4'hE, {2'h3, 3'h4}, 8'h00, 1'b0);
    chk(8'(dtr_n), 8'h0F, "dtr ch3 high");
    reset_pin = 1'b0;
    mode_16 = 1'b1;
    step(6);
    $display("test mode0 done");
  endtask

  task automatic t_mode1;
    bus(4'hB, 5'h04, 8'h01, 1'b0);
    chk(8'(dtr_n), 8'h0B, "dtr ch2 low");
    bus(4'hB, 5'h04, 8'h00, 1'b1);
    chk(q, 8'h01, "control read back");
    bus(4'hB, 5'h04, 8'h00, 1'b0);
    chk(8'(dtr_n), 8'h0F, "dtr ch2 high");
    bus(4'hD, 5'h01, 8'h5A, 1'b0);
    bus(4'hB, 5'h01, 8'h00, 1'b1);
    chk(q, 8'hA2, "ch2 untouched");
    bus(4'hD, 5'h01, 8'h00, 1'b1);
    chk(q, 8'h5A, "ch1 write lands");
    bus(4'hF, 5'h01, 8'h00, 1'b1);
    chk(8'(e), 8'h00, "no channel selected");
    $display("test mode1 done");
  endtask

  task automatic t_ready;
    logic [3:0] pat [7];
    pat = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};
    for (int i = 0; i < 7; i++)
    begin
      rx_s = pat[i];
      tx_s = pat[i];
      step(2);
      chk(8'(rxr_n), 8'(~|pat[i]), "receive ready");
      chk(8'(txr_n), 8'(~|pat[i]), "transmit ready");
    end
    rx_s = 4'h2;
    tx_s = 4'h2;
    step(2);
    bus(4'hD, 5'h05, 8'h00, 1'b1);
    chk(q & 8'h21, 8'h21, "ch1 line status");
    bus(4'hE, 5'h05, 8'h00, 1'b1);
    chk(q & 8'h21, 8'h00, "ch0 line status");
    $display("test ready done");
  endtask

  task automatic t_modem;
    for (int p = 0; p < 2; p++)
    begin
      car_s = p ? 4'hA : 4'h5;
      cts_s = p ? 4'hC : 4'h3;
      dsr_s = p ? 4'h6 : 4'h9;
      step(4);
      for (int c = 0; c < 4; c++)
      begin
        bus(~(4'h1 << c), 5'h06, 8'h00, 1'b1);
        chk(q, {car_s[c], 1'b0, dsr_s[c], cts_s[c], 4'h0}, "modem status");
      end
      chk(8'({tx_en, rx_en}), 8'hFF, "modem lines never gate");
    end
    $display("test modem done");
  endtask

  task automatic t_clock;
    ticks = 0;
    repeat (5)
    begin
      xin = 1'b1;
      step(3);
      chk(8'(osc), 8'h01, "oscillator out high");
      xin = 1'b0;
      step(3);
      chk(8'(osc), 8'h00, "oscillator out low");
    end
    chk(8'(ticks), 8'h05, "reference ticks");
    $display("test clock done");
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    mode_16 = 1'b1;
    reset_pin = 1'b0;
    {rd_n, wr_n, rw_n, xin} = 4'hE;
    chip_sel_n = 4'hF;
    addr = 5'h00;
    din = 8'h00;
    {rx_s, car_s, cts_s, dsr_s} = 16'h0000;
    tx_s = 4'hF;
    step(12);
    t_reset();
    t_mode0();
    t_mode1();
    t_ready();
    t_modem();
    t_clock();
    final_report();
  end
endmodule

`default_nettype wire
